//--- dv/iwd_fetch_model.sv
// Fetch path model: hands one program word to the decoder per request.
// Assumes the bench raises req_valid at the phase-3 cycle only.
`timescale 1ns/1ns
module iwd_fetch_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] req_word,
    input  wire logic        req_valid,
    output logic [15:0]      word,
    output logic             word_valid
);
    logic [15:0] last_q = 16'h0000;
    always_ff @(posedge sys_clk) begin
        if (req_valid) begin
            last_q <= req_word;
        end
    end
    // Released bus shows the inverse, so stale words never pass for fresh ones
    assign word       = req_valid ? req_word : ~last_q;
    assign word_valid = req_valid;
endmodule

//--- dv/tb_instruction_word_decoder.sv
// Self-checking bench of the instruction word decoder.
// Assumes the fetch model beside it; inputs change at the falling edge.
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_instruction_word_decoder;
    logic SYS_CLK = 1'b0, RST = 1'b1, CE = 1'b1, TAKEN = 1'b0, rv = 1'b0, WORD_VALID, CYCLE_STROBE;
    logic DEST_FILE, CALL_MODE, DOUBLE_WORD, EXEC_NOP;
    logic [15:0] rw = 16'h0000, WORD, OPCODE_WORD;
    logic [3:0] BANK_SEL = 4'ha, BANK;
    logic [1:0] PHASE, POINTER_SEL, TABLE_MODE, CYCLES;
    logic [7:0] FILE_ADDR, LITERAL;
    logic [2:0] BIT_NUM;
    logic [19:0] PROG_ADDR;
    iwd_pkg::iwd_class_t INSTR_CLASS;
    int n_mismatch = 0, tests_run = 0;
    always #5 SYS_CLK = ~SYS_CLK;
    iwd_fetch_model iwd_fetch_model_i (.sys_clk(SYS_CLK), .req_word(rw), .req_valid(rv), .word(WORD),
        .word_valid(WORD_VALID));
    iwd_decoder iwd_decoder_i (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .WORD(WORD), .WORD_VALID(WORD_VALID),
        .TAKEN(TAKEN), .BANK_SEL(BANK_SEL), .CYCLE_STROBE(CYCLE_STROBE), .PHASE(PHASE),
        .INSTR_CLASS(INSTR_CLASS), .OPCODE_WORD(OPCODE_WORD), .FILE_ADDR(FILE_ADDR), .BANK(BANK),
        .DEST_FILE(DEST_FILE), .BIT_NUM(BIT_NUM), .LITERAL(LITERAL), .POINTER_SEL(POINTER_SEL),
        .PROG_ADDR(PROG_ADDR), .CALL_MODE(CALL_MODE), .TABLE_MODE(TABLE_MODE), .DOUBLE_WORD(DOUBLE_WORD),
        .EXEC_NOP(EXEC_NOP), .CYCLES(CYCLES));
    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Presents one word over the phase-3 edge; returns where the answer stands
    task automatic issue(input logic [15:0] w, input logic tk);
        int n;
        n = 0;
        while (PHASE !== 2'h3 && n < 12) begin
            @(negedge SYS_CLK);
            n++;
        end
        rw = w;
        rv = 1'b1;
        TAKEN = tk;
        @(negedge SYS_CLK);
        rv = 1'b0;
        TAKEN = 1'b0;
        `CHK(CYCLE_STROBE, 1'b1)
        `CHK(PHASE, 2'h0)
    endtask
    task automatic byte_ops();
        for (int i = 0; i < 4; i++) begin
            issue(16'h5c00 | 16'(i << 8) | 16'(8'h3c + i), 1'b0);
            `CHK(FILE_ADDR, 8'(8'h3c + i))
            `CHK(DEST_FILE, i[1])
            `CHK(BANK, (i[0] ? 4'ha : 4'h0))
            `CHK(CYCLES, 2'h1)
            `CHK(EXEC_NOP, 1'b0)
            `CHK(OPCODE_WORD, 16'h5c00 | 16'(i << 8) | 16'(8'h3c + i))
        end
    endtask
    task automatic bit_op_taken();
        issue(16'hbb55, 1'b1);
        `CHK(BIT_NUM, 3'h5)
        `CHK(FILE_ADDR, 8'h55)
        `CHK(BANK, 4'ha)
        `CHK(CYCLES, 2'h2)
        repeat (4) @(negedge SYS_CLK);
        `CHK(EXEC_NOP, 1'b1)
    endtask
    task automatic double_words();
        issue(16'hef12, 1'b0);
        issue(16'h1234, 1'b0);
        `CHK(OPCODE_WORD, 16'hef12)
        `CHK(DOUBLE_WORD, 1'b1)
        issue(16'hf345, 1'b0);
        `CHK(PROG_ADDR, 20'h34512)
        `CHK(DOUBLE_WORD, 1'b1)
        `CHK(CYCLES, 2'h2)
        issue(16'hed12, 1'b0);
        issue(16'hf3a7, 1'b0);
        `CHK(CALL_MODE, 1'b1)
        `CHK(PROG_ADDR, 20'h3a712)
        issue(16'hee20, 1'b0);
        issue(16'hf0c7, 1'b0);
        `CHK(POINTER_SEL, 2'h2)
        `CHK(LITERAL, 8'hc7)
        `CHK(CYCLES, 2'h2)
    endtask
    task automatic lone_second();
        repeat (8) @(negedge SYS_CLK);
        issue(16'hf0f0, 1'b0);
        `CHK(INSTR_CLASS, iwd_pkg::IWD_CLS_SECOND)
        `CHK(EXEC_NOP, 1'b1)
    endtask
    task automatic control_ops();
        issue(16'he210, 1'b0);
        `CHK(INSTR_CLASS, iwd_pkg::IWD_CLS_CTRL)
        `CHK(CYCLES, 2'h1)
        issue(16'hd005, 1'b0);
        `CHK(PROG_ADDR, 20'h00005)
        `CHK(CYCLES, 2'h2)
        repeat (4) @(negedge SYS_CLK);
        `CHK(EXEC_NOP, 1'b1)
        issue(16'h0013, 1'b0);
        `CHK(CALL_MODE, 1'b1)
        `CHK(CYCLES, 2'h2)
        repeat (4) @(negedge SYS_CLK);
        `CHK(EXEC_NOP, 1'b1)
        issue(16'h0009, 1'b0);
        `CHK(TABLE_MODE, 2'h1)
        `CHK(CYCLES, 2'h1)
        issue(16'h0c5a, 1'b0);
        `CHK(INSTR_CLASS, iwd_pkg::IWD_CLS_LIT)
        `CHK(LITERAL, 8'h5a)
        `CHK(CYCLES, 2'h2)
        repeat (4) @(negedge SYS_CLK);
        `CHK(EXEC_NOP, 1'b1)
    endtask
    task automatic freeze_and_reset();
        logic [1:0] ph;
        @(negedge SYS_CLK);
        ph = PHASE;
        CE = 1'b0;
        repeat (6) @(negedge SYS_CLK);
        `CHK(PHASE, ph)
        CE = 1'b1;
        @(negedge SYS_CLK);
        `CHK(PHASE, 2'(ph + 2'h1))
        RST = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        `CHK(INSTR_CLASS, iwd_pkg::IWD_CLS_NONE)
        `CHK(PHASE, 2'h0)
        `CHK(CYCLES, 2'h0)
        RST = 1'b0;
        issue(16'h6f21, 1'b0);
        `CHK(INSTR_CLASS, iwd_pkg::IWD_CLS_BYTE)
        `CHK(FILE_ADDR, 8'h21)
        `CHK(DEST_FILE, 1'b1)
        `CHK(BANK, 4'ha)
    endtask
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge SYS_CLK);
        RST = 1'b0;
        byte_ops();
        bit_op_taken();
        double_words();
        control_ops();
        lone_second();
        freeze_and_reset();
        conclude();
    end
endmodule

//--- src/iwd_cfg.svh
// Constants of the instruction word decoder: field positions, codes, timing.
// Assumes a single clock domain; included by the decoder module only.
// How it works
// - Each instruction is one 16-bit word, except three that take two words.
// - A word splits into an opcode part and operand fields.
// - A second word carries ones in its top four bits, operands below.
// - A second word fetched alone executes as a no-operation.
// - Single-word: one cycle; taken test or program counter change adds a no-op cycle.
// - Each double-word instruction takes two instruction cycles.
// - One instruction cycle is four oscillator periods.
// - Destination zero writes the working register, one writes the file register.
// - Byte instructions decode file address, destination and access select.
// - Bit instructions decode file address, access select and bit number.
// - Literal instructions decode a literal and, where present, a pointer number.
// - Control instructions decode address, call/return mode or table mode fields.
// - Access select zero forces the access bank; one uses the bank select register.
`ifndef IWD_CFG_SVH
`define IWD_CFG_SVH
`define IWD_PHASES      3'h4
`define IWD_SECOND_TAG  4'hf
`define IWD_F_LSB       0
`define IWD_A_BIT       8
`define IWD_D_BIT       9
`define IWD_B_LSB       9
`define IWD_CALL_FIRST  7'h76
`define IWD_GOTO_FIRST  8'hef
`define IWD_LFSR_FIRST  10'h3b8
`define IWD_ACCESS_BANK 4'h0
`define IWD_BRA_NIB     4'hd
`define IWD_BRANCH_NIB  4'he
`define IWD_MISC_HIGH   8'h00
`define IWD_RETFIE_LOW  7'h08
`define IWD_RETURN_LOW  7'h09
`define IWD_RETLW_HIGH  8'h0c
`endif

//--- src/iwd_decoder.sv
// Instruction word decoder and cycle sequencer.
// Assumes words arrive from same-clock fetch logic, one per instruction cycle on WORD_VALID.
`timescale 1ns/1ns
`include "iwd_cfg.svh"
module iwd_decoder (
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST,
    input  wire logic                 CE,
    input  wire logic [15:0]          WORD,
    input  wire logic                 WORD_VALID,
    input  wire logic                 TAKEN,
    input  wire logic [3:0]           BANK_SEL,
    output logic                      CYCLE_STROBE,
    output logic [1:0]                PHASE,
    output iwd_pkg::iwd_class_t       INSTR_CLASS,
    output logic [15:0]               OPCODE_WORD,
    output logic [7:0]                FILE_ADDR,
    output logic [3:0]                BANK,
    output logic                      DEST_FILE,
    output logic [2:0]                BIT_NUM,
    output logic [7:0]                LITERAL,
    output logic [1:0]                POINTER_SEL,
    output logic [19:0]               PROG_ADDR,
    output logic                      CALL_MODE,
    output logic [1:0]                TABLE_MODE,
    output logic                      DOUBLE_WORD,
    output logic                      EXEC_NOP,
    output logic [1:0]                CYCLES
);
    typedef struct packed {
        logic [1:0]          phase;
        logic                strobe;
        iwd_pkg::iwd_state_t st;
        iwd_pkg::iwd_class_t cls;
        logic [15:0]         op;
        logic [7:0]          f;
        logic [3:0]          bank;
        logic                d;
        logic [2:0]          b;
        logic [7:0]          k;
        logic [1:0]          ptr;
        logic [19:0]         addr;
        logic                s;
        logic [1:0]          m;
        logic                dbl;
        logic                nop;
        logic [1:0]          cycles;
    } iwd_state_s_t;

    iwd_state_s_t s_q;
    iwd_state_s_t s_d;
    logic         cyc_end;
    // Opcode groups, decoded once so the sequencer and the checks agree
    logic [3:0]   top_nib;
    logic         is_second;
    logic         is_call;
    logic         is_goto;
    logic         is_ptr_load;
    logic         is_double;
    logic         is_bit;
    logic         is_rel;
    logic         is_cond;
    logic         is_misc;
    logic         is_ret;
    logic         is_ctrl;
    logic         is_lit;
    logic         is_retlw;
    logic         fetch_take;
    logic         second_take;

    always_comb begin
        top_nib     = WORD[15:12];
        is_second   = (top_nib == `IWD_SECOND_TAG);
        is_call     = (WORD[15:9] == `IWD_CALL_FIRST);
        is_goto     = (WORD[15:8] == `IWD_GOTO_FIRST);
        is_ptr_load = (WORD[15:6] == `IWD_LFSR_FIRST);
        is_double   = is_call || is_goto || is_ptr_load;
        is_bit      = (top_nib >= 4'h7 && top_nib <= 4'hb);
        is_rel      = (top_nib == `IWD_BRA_NIB);
        is_cond     = (top_nib == `IWD_BRANCH_NIB);
        is_misc     = (WORD[15:8] == `IWD_MISC_HIGH);
        is_ret      = is_misc && (WORD[7:1] == `IWD_RETFIE_LOW || WORD[7:1] == `IWD_RETURN_LOW);
        is_ctrl     = is_rel || is_cond || is_misc;
        is_lit      = (top_nib == 4'h0 || WORD[15:11] == 5'h1c);
        is_retlw    = (WORD[15:8] == `IWD_RETLW_HIGH);
        fetch_take  = CE && cyc_end && s_q.st == iwd_pkg::IWD_FETCH && WORD_VALID;
        second_take = CE && cyc_end && s_q.st == iwd_pkg::IWD_WORD2 && WORD_VALID && is_second;
    end

    always_comb begin
        s_d = s_q;
        s_d.strobe = 1'b0;
        cyc_end = (s_q.phase == 2'(`IWD_PHASES - 3'h1));
        s_d.phase = s_q.phase + 2'h1;
        if (cyc_end) begin
            s_d.strobe = 1'b1;
            unique case (s_q.st)
                iwd_pkg::IWD_FETCH: begin
                    if (WORD_VALID) begin
                        s_d.op = WORD;
                        s_d.nop = 1'b0;
                        s_d.dbl = 1'b0;
                        s_d.cycles = 2'h1;
                        s_d.f = WORD[`IWD_F_LSB +: 8];
                        s_d.d = WORD[`IWD_D_BIT];
                        s_d.b = WORD[`IWD_B_LSB +: 3];
                        s_d.k = WORD[7:0];
                        s_d.bank = WORD[`IWD_A_BIT] ? BANK_SEL : `IWD_ACCESS_BANK;
                        s_d.ptr = WORD[5:4];
                        s_d.s = WORD[0];
                        s_d.m = WORD[1:0];
                        s_d.addr = {12'h000, WORD[7:0]};
                        s_d.st = iwd_pkg::IWD_FETCH;
                        if (is_second) begin
                            s_d.cls = iwd_pkg::IWD_CLS_SECOND;
                            s_d.nop = 1'b1;
                        end else if (is_double) begin
                            s_d.dbl = 1'b1;
                            s_d.cycles = 2'h2;
                            s_d.cls = is_ptr_load ? iwd_pkg::IWD_CLS_LIT : iwd_pkg::IWD_CLS_CTRL;
                            s_d.s = WORD[8];
                            s_d.st = iwd_pkg::IWD_WORD2;
                        end else if (is_bit) begin
                            s_d.cls = iwd_pkg::IWD_CLS_BIT;
                            // Bit tests that skip arrive with TAKEN high
                            if (TAKEN) begin
                                s_d.cycles = 2'h2;
                                s_d.st = iwd_pkg::IWD_EXTRA;
                            end
                        end else if (is_ctrl) begin
                            s_d.cls = iwd_pkg::IWD_CLS_CTRL;
                            s_d.addr = is_rel ? {9'h000, WORD[10:0]} : {12'h000, WORD[7:0]};
                            if (is_rel || is_ret || (is_cond && TAKEN)) begin
                                s_d.cycles = 2'h2;
                                s_d.st = iwd_pkg::IWD_EXTRA;
                            end
                        end else if (is_lit) begin
                            s_d.cls = iwd_pkg::IWD_CLS_LIT;
                            // A literal return still changes the program counter
                            if (is_retlw) begin
                                s_d.cycles = 2'h2;
                                s_d.st = iwd_pkg::IWD_EXTRA;
                            end
                        end else begin
                            s_d.cls = iwd_pkg::IWD_CLS_BYTE;
                            if (TAKEN) begin
                                s_d.cycles = 2'h2;
                                s_d.st = iwd_pkg::IWD_EXTRA;
                            end
                        end
                    end else begin
                        s_d.cls = iwd_pkg::IWD_CLS_NONE;
                        s_d.nop = 1'b1;
                    end
                end
                iwd_pkg::IWD_EXTRA: begin
                    s_d.nop = 1'b1;
                    s_d.st = iwd_pkg::IWD_FETCH;
                end
                iwd_pkg::IWD_WORD2: begin
                    // Stall until the second word shows up
                    if (WORD_VALID && WORD[15:12] == `IWD_SECOND_TAG) begin
                        s_d.addr = {WORD[11:0], s_q.op[7:0]};
                        s_d.k = WORD[7:0];
                        s_d.f = {4'h0, s_q.op[3:0]};
                        s_d.st = iwd_pkg::IWD_FETCH;
                    end
                end
                default: begin
                    s_d.st = iwd_pkg::IWD_FETCH;
                end
            endcase
        end
        if (RST) begin
            s_d = '0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST || CE) begin
            s_q <= s_d;
        end
    end

    assign CYCLE_STROBE = s_q.strobe;
    assign PHASE        = s_q.phase;
    assign INSTR_CLASS  = s_q.cls;
    assign OPCODE_WORD  = s_q.op;
    assign FILE_ADDR    = s_q.f;
    assign BANK         = s_q.bank;
    assign DEST_FILE    = s_q.d;
    assign BIT_NUM      = s_q.b;
    assign LITERAL      = s_q.k;
    assign POINTER_SEL  = s_q.ptr;
    assign PROG_ADDR    = s_q.addr;
    assign CALL_MODE    = s_q.s;
    assign TABLE_MODE   = s_q.m;
    assign DOUBLE_WORD  = s_q.dbl;
    assign EXEC_NOP     = s_q.nop;
    assign CYCLES       = s_q.cycles;

    strobe_period_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && CYCLE_STROBE) ##1 (CE [*4]) |-> CYCLE_STROBE)
        else $error("Cycle strobe not every four periods");
    second_nop_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (INSTR_CLASS == iwd_pkg::IWD_CLS_SECOND) |-> EXEC_NOP)
        else $error("Lone second word not a no-op");
    double_cycles_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        DOUBLE_WORD |-> CYCLES == 2'h2)
        else $error("Double word not two cycles");
    access_bank_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && cyc_end && s_q.st == iwd_pkg::IWD_FETCH && WORD_VALID && !WORD[8] && WORD[15:12] != 4'hf)
        |=> BANK == `IWD_ACCESS_BANK)
        else $error("Access select zero did not force access bank");
    dest_field_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && cyc_end && s_q.st == iwd_pkg::IWD_FETCH && WORD_VALID) |=> DEST_FILE == $past(WORD[9]))
        else $error("Destination select mismatch");
    single_cycle_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CYCLES == 2'h1 && CYCLE_STROBE) |-> !DOUBLE_WORD)
        else $error("Single cycle on double word");
    extra_nop_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && cyc_end && s_q.st == iwd_pkg::IWD_EXTRA) |=> EXEC_NOP)
        else $error("Extra cycle not a no-op");
    bit_field_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && cyc_end && s_q.st == iwd_pkg::IWD_FETCH && WORD_VALID) |=> BIT_NUM == $past(WORD[11:9]))
        else $error("Bit number mismatch");
    // Field capture and sequencing checks
    opcode_capture_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        fetch_take |=> OPCODE_WORD == $past(WORD))
        else $error("Opcode word not captured");
    file_field_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        fetch_take |=> FILE_ADDR == $past(WORD[7:0]))
        else $error("File address mismatch");
    literal_field_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        fetch_take |=> LITERAL == $past(WORD[7:0]))
        else $error("Literal mismatch");
    pointer_field_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        fetch_take |=> POINTER_SEL == $past(WORD[5:4]))
        else $error("Pointer number mismatch");
    table_mode_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        fetch_take |=> TABLE_MODE == $past(WORD[1:0]))
        else $error("Table mode mismatch");
    bank_select_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && WORD[8]) |=> BANK == $past(BANK_SEL))
        else $error("Bank select not used");
    second_class_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && is_second) |=> INSTR_CLASS == iwd_pkg::IWD_CLS_SECOND && EXEC_NOP)
        else $error("Lone second word not classed as no-op");
    fetch_busy_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && !is_second) |=> !EXEC_NOP)
        else $error("Fetched instruction marked no-op");
    double_start_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && is_double) |=> DOUBLE_WORD && s_q.st == iwd_pkg::IWD_WORD2)
        else $error("Double word not awaiting second word");
    word2_stall_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && cyc_end && s_q.st == iwd_pkg::IWD_WORD2 && !(WORD_VALID && is_second))
        |=> s_q.st == iwd_pkg::IWD_WORD2)
        else $error("Untagged word taken as second word");
    word2_addr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        second_take |=> PROG_ADDR == {$past(WORD[11:0]), $past(s_q.op[7:0])})
        else $error("Program address not joined");
    word2_literal_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        second_take |=> LITERAL == $past(WORD[7:0]))
        else $error("Second word literal mismatch");
    word2_done_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        second_take |=> s_q.st == iwd_pkg::IWD_FETCH && DOUBLE_WORD && CYCLES == 2'h2)
        else $error("Double word did not finish in two cycles");
    rel_two_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && is_rel) |=> CYCLES == 2'h2 && s_q.st == iwd_pkg::IWD_EXTRA)
        else $error("Relative branch not two cycles");
    taken_two_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && TAKEN && (is_bit || is_cond)) |=> CYCLES == 2'h2)
        else $error("True test not two cycles");
    cond_idle_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && is_cond && !is_double && !TAKEN) |=> CYCLES == 2'h1)
        else $error("Untaken branch not one cycle");
    phase_step_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        CE |=> PHASE == $past(PHASE) + 2'h1)
        else $error("Phase did not advance");
    ce_freeze_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !CE |=> $stable(PHASE) && $stable(INSTR_CLASS) && $stable(OPCODE_WORD))
        else $error("State moved while clock enable low");
    strobe_phase_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        CYCLE_STROBE |-> PHASE == 2'h0)
        else $error("Cycle strobe off phase zero");
    call_mode_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && is_double) |=> CALL_MODE == $past(WORD[8]))
        else $error("Call mode mismatch");
    extra_done_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && cyc_end && s_q.st == iwd_pkg::IWD_EXTRA) |=> s_q.st == iwd_pkg::IWD_FETCH)
        else $error("Extra cycle did not return to fetch");
    class_byte_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && !(is_second || is_double || is_bit || is_ctrl || is_lit)) |=> INSTR_CLASS == iwd_pkg::IWD_CLS_BYTE)
        else $error("Byte instruction misclassed");
    class_bit_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (fetch_take && is_bit) |=> INSTR_CLASS == iwd_pkg::IWD_CLS_BIT)
        else $error("Bit instruction misclassed");
    dbl_seen_c: cover property (@(posedge SYS_CLK) DOUBLE_WORD && CYCLE_STROBE);
    extra_seen_c: cover property (@(posedge SYS_CLK) s_q.st == iwd_pkg::IWD_EXTRA);
    lone_second_c: cover property (@(posedge SYS_CLK) INSTR_CLASS == iwd_pkg::IWD_CLS_SECOND);
    ce_freeze_c: cover property (@(posedge SYS_CLK) !CE && !RST);
    retlw_extra_c: cover property (@(posedge SYS_CLK) fetch_take && is_retlw);
endmodule

//--- src/iwd_pkg.sv
// Types of the instruction word decoder.
// Assumes the constants header sits beside it.
package iwd_pkg;
    typedef enum logic [2:0] {
        IWD_CLS_NONE,
        IWD_CLS_BYTE,
        IWD_CLS_BIT,
        IWD_CLS_LIT,
        IWD_CLS_CTRL,
        IWD_CLS_SECOND
    } iwd_class_t;
    typedef enum logic [1:0] {
        IWD_FETCH,
        IWD_EXTRA,
        IWD_WORD2
    } iwd_state_t;
endpackage
